// >>> rfir_top.sv
// fault source, soft reset and top interrupt flag registers
`timescale 1ns/1ps
module rfir_top
    import rfir_pkg::*;
#(
    parameter int NREG = NUM_REG
) (
    input  wire logic            CLK,
    input  wire logic            RST,
    input  wire logic            REG_WR,
    input  wire logic            REG_RD,
    input  wire logic [7:0]      REG_ADDR,
    input  wire logic [7:0]      REG_WDATA,
    output logic      [7:0]      REG_RDATA,
    input  wire logic [NREG-1:0] OUTPUT_VALID,
    input  wire logic [NREG-1:0] POWER_OK_SOURCE,
    input  wire logic            FAULT_GATING_SELECT,
    input  wire logic            EXT_CLK_PRESENT,
    input  wire logic            THERMAL_SHUTDOWN_LIVE,
    input  wire logic            THERMAL_WARNING_LIVE,
    input  wire logic            INPUT_OVERVOLTAGE_LIVE,
    input  wire logic            LOAD_CURRENT_DONE,
    input  wire logic [7:0]      STEPDOWN_IRQ_REGISTER,
    input  wire logic [7:0]      LINREG_IRQ_REGISTER,
    input  wire logic [7:0]      TOP_IRQ_MASK,
    input  wire logic [NREG-1:0] REG_ENABLE_REQ,
    output logic [NREG-1:0]      REG_ENABLE,
    output logic                 GENERAL_OUTPUT_A,
    output logic                 GENERAL_OUTPUT_B,
    input  wire logic            GENERAL_REQ_A,
    input  wire logic            GENERAL_REQ_B,
    output logic                 POWER_OK_OUTPUT,
    output logic                 SOFT_RESET_PULSE,
    output logic                 IRQ
);
    // the fault register holds exactly four regulator bits
    if (NREG != NUM_REG) begin : g_bad_nreg
        $error("rfir_top: four regulators only");
    end

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    // analog monitor pins are asynchronous; all pass two flops first
    localparam int SW = NREG + 5;
    logic [SW-1:0] raw_in;
    logic [SW-1:0] sync_in;
    logic [NREG-1:0] valid_s;
    logic clk_s;
    logic tsd_s;
    logic twarn_s;
    logic ovp_s;
    logic meas_s;

    assign raw_in = {LOAD_CURRENT_DONE, INPUT_OVERVOLTAGE_LIVE, THERMAL_WARNING_LIVE,
                     THERMAL_SHUTDOWN_LIVE, EXT_CLK_PRESENT, OUTPUT_VALID};

    rfir_sync #(.WIDTH(SW)) u_sync (
        .clk  (CLK),
        .rst  (RST),
        .din  (raw_in),
        .dout (sync_in)
    );

    assign valid_s = sync_in[NREG-1:0];
    assign clk_s   = sync_in[NREG];
    assign tsd_s   = sync_in[NREG+1];
    assign twarn_s = sync_in[NREG+2];
    assign ovp_s   = sync_in[NREG+3];
    assign meas_s  = sync_in[NREG+4];

    function automatic logic wr_hit(input logic w, input logic [7:0] a, input logic [7:0] t);
        return w && (a == t);
    endfunction : wr_hit

    // ---------------------------------------------------------------
    // state registers
    // ---------------------------------------------------------------
    logic [NREG-1:0] fault_flag;
    logic [NREG-1:0] next_fault_flag;
    logic [7:0]      top_flag;
    logic [7:0]      next_top_flag;
    logic            soft_reset;
    logic            next_soft_reset;
    logic            pok;
    logic            next_pok;
    logic            clk_prev;
    logic            meas_prev;
    logic            tsd_prev;
    logic            twarn_prev;
    logic            ovp_prev;
    logic [7:0]      next_rdata;
    logic [7:0]      top_view;
    logic [NREG-1:0] live_bad;
    logic            wr_fault;
    logic            wr_top;
    logic            wr_rst;
    logic            any_reset;
    logic [1:0]      warm;
    logic [1:0]      next_warm;

    assign wr_fault  = wr_hit(REG_WR, REG_ADDR, ADDR_FAULT_SRC);
    assign wr_top    = wr_hit(REG_WR, REG_ADDR, ADDR_TOP_FLAGS);
    assign wr_rst    = wr_hit(REG_WR, REG_ADDR, ADDR_SOFT_RESET);
    // soft reset acts one cycle after the write, like a local reset
    assign any_reset = RST || soft_reset;
    // synchroniser outputs read as invalid until refilled after a reset,
    // so fault capture and power-ok wait for two real samples
    always_ff @(posedge CLK) begin
        if (RST) begin
            warm <= '0;
        end else begin
            warm <= next_warm;
        end
    end
    // (R16) source enable gating
    assign live_bad  = (POWER_OK_SOURCE & ~valid_s) & {NREG{warm[1]}};

    always_comb begin
        next_fault_flag = fault_flag;
        next_top_flag   = top_flag & TOP_LATCH_MASK;
        // (R2) clear only while valid
        next_fault_flag = fault_flag & ~(REG_WDATA[NREG-1:0] & valid_s & {NREG{wr_fault}});
        // (R1) set wins over clear
        next_fault_flag = next_fault_flag | live_bad;
        // (R15) gated or live power-ok, low until inputs are known
        if (FAULT_GATING_SELECT) begin
            next_pok = warm[1] && (next_fault_flag == FAULT_RESET);
        end else begin
            next_pok = warm[1] && (live_bad == FAULT_RESET);
        end
        // (R14) write one to clear
        if (wr_top) begin
            next_top_flag = next_top_flag & ~(REG_WDATA & TOP_LATCH_MASK);
        end
        // (R5) power-ok drop edge
        if (pok && !next_pok) begin
            next_top_flag[BIT_POK_DROP] = 1'b1;
        end
        // (R8) clock appears or disappears
        if (clk_s != clk_prev) begin
            next_top_flag[BIT_CLK_SYNC] = 1'b1;
        end
        // (R9) thermal shutdown latch
        if (tsd_s && !tsd_prev) begin
            next_top_flag[BIT_THERM_SD] = 1'b1;
        end
        // (R11) warning latch
        if (twarn_s && !twarn_prev) begin
            next_top_flag[BIT_THERM_WARN] = 1'b1;
        end
        // (R12) overvoltage latch
        if (ovp_s && !ovp_prev) begin
            next_top_flag[BIT_OVERVOLT] = 1'b1;
        end
        // (R13) new measurement
        if (meas_s && !meas_prev) begin
            next_top_flag[BIT_LOAD_MEAS] = 1'b1;
        end
    end

    always_comb begin
        // (R3) soft reset request
        next_soft_reset = wr_rst && REG_WDATA[BIT_SOFT_RESET];
        next_warm       = {warm[0], 1'b1};
    end

    // (R3) registers to defaults
    always_ff @(posedge CLK) begin
        if (any_reset) begin
            fault_flag <= FAULT_RESET;
            top_flag   <= RESET_VALUE;
            pok        <= 1'b0;
            clk_prev   <= 1'b0;
            meas_prev  <= 1'b0;
            tsd_prev   <= 1'b0;
            twarn_prev <= 1'b0;
            ovp_prev   <= 1'b0;
        end else begin
            fault_flag <= next_fault_flag;
            top_flag   <= next_top_flag;
            pok        <= next_pok;
            clk_prev   <= clk_s;
            meas_prev  <= meas_s;
            tsd_prev   <= tsd_s;
            twarn_prev <= twarn_s;
            ovp_prev   <= ovp_s;
        end
    end

    // (R4) self-clearing command
    always_ff @(posedge CLK) begin
        if (any_reset) begin
            soft_reset <= 1'b0;
        end else begin
            soft_reset <= next_soft_reset;
        end
    end

    // ---------------------------------------------------------------
    // read path and outputs
    // ---------------------------------------------------------------
    always_comb begin
        top_view = top_flag & TOP_LATCH_MASK;
        // (R6) linreg summary
        top_view[BIT_LINREG_SUM] = |LINREG_IRQ_REGISTER;
        // (R7) stepdown summary
        top_view[BIT_STEP_SUM]   = |STEPDOWN_IRQ_REGISTER;
        next_rdata = RESET_VALUE;
        if (REG_RD) begin
            unique case (REG_ADDR)
                ADDR_FAULT_SRC:  next_rdata = {4'h0, fault_flag};
                // (R4) command bit never reads back set
                ADDR_SOFT_RESET: next_rdata = RESET_VALUE;
                ADDR_TOP_FLAGS:  next_rdata = top_view;
                default:         next_rdata = RESET_VALUE;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (any_reset) begin
            REG_RDATA <= RESET_VALUE;
        end else begin
            REG_RDATA <= next_rdata;
        end
    end

    logic shut;
    assign shut = top_flag[BIT_THERM_SD] || top_flag[BIT_OVERVOLT] || tsd_s || ovp_s;
    // (R10) enables blocked while shutdown latched
    assign REG_ENABLE       = shut ? '0 : REG_ENABLE_REQ;
    // (R9) outputs low on fault
    assign GENERAL_OUTPUT_A = GENERAL_REQ_A && !shut;
    assign GENERAL_OUTPUT_B = GENERAL_REQ_B && !shut;
    assign POWER_OK_OUTPUT  = pok;
    assign SOFT_RESET_PULSE = soft_reset;
    // (R17) masked interrupt output
    assign IRQ = |(top_view & ~TOP_IRQ_MASK);

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    sequence s_rst_write;
        wr_rst && REG_WDATA[BIT_SOFT_RESET];
    endsequence

    // (R1) (R2) one pair of checks per regulator bit
    for (genvar g = 0; g < NREG; g++) begin : g_fault_chk
        property p_fault_set;
            @(posedge CLK) disable iff (any_reset) live_bad[g] |=> fault_flag[g];
        endproperty
        a_fault_set: assert property (p_fault_set) else $error("fault flag not set"); // (R1)

        property p_fault_hold;
            @(posedge CLK) disable iff (any_reset)
                (fault_flag[g] && !valid_s[g]) |=> fault_flag[g];
        endproperty
        a_fault_hold: assert property (p_fault_hold) else $error("fault cleared early"); // (R2)
    end

    property p_soft_reset;
        @(posedge CLK) disable iff (RST) s_rst_write |=> ##1 (top_flag == RESET_VALUE);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset no effect"); // (R3)

    property p_self_clear;
        @(posedge CLK) disable iff (RST) soft_reset |=> !soft_reset;
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("reset bit stuck"); // (R4)

    // a reset pulls power-ok low without it counting as a drop
    property p_pok_drop;
        @(posedge CLK) disable iff (any_reset)
            (!$past(any_reset) && $fell(pok)) |-> top_flag[BIT_POK_DROP];
    endproperty
    a_pok_drop: assert property (p_pok_drop) else $error("drop flag missed"); // (R5)

    property p_linreg_sum;
        @(posedge CLK) disable iff (any_reset)
            (REG_RD && (REG_ADDR == ADDR_TOP_FLAGS) && (LINREG_IRQ_REGISTER != 8'h00))
            |=> REG_RDATA[BIT_LINREG_SUM];
    endproperty
    a_linreg_sum: assert property (p_linreg_sum) else $error("linreg summary wrong"); // (R6)

    property p_shut_block;
        @(posedge CLK) disable iff (any_reset) top_flag[BIT_THERM_SD] |-> (REG_ENABLE == '0);
    endproperty
    a_shut_block: assert property (p_shut_block) else $error("enabled in shutdown"); // (R10)

    property p_irq;
        @(posedge CLK) disable iff (any_reset)
            (top_flag[BIT_OVERVOLT] && !TOP_IRQ_MASK[BIT_OVERVOLT]) |-> IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing"); // (R17)

    property p_step_sum;
        @(posedge CLK) disable iff (any_reset)
            (REG_RD && (REG_ADDR == ADDR_TOP_FLAGS) && (STEPDOWN_IRQ_REGISTER != 8'h00))
            |=> REG_RDATA[BIT_STEP_SUM];
    endproperty
    a_step_sum: assert property (p_step_sum) else $error("stepdown summary wrong"); // (R7)

    property p_sync_latch;
        @(posedge CLK) disable iff (any_reset) (clk_s != clk_prev) |=> top_flag[BIT_CLK_SYNC];
    endproperty
    a_sync_latch: assert property (p_sync_latch) else $error("clock flag missed"); // (R8)

    property p_meas_latch;
        @(posedge CLK) disable iff (any_reset)
            (meas_s && !meas_prev) |=> top_flag[BIT_LOAD_MEAS];
    endproperty
    a_meas_latch: assert property (p_meas_latch) else $error("measure flag missed"); // (R13)

    property p_top_clear;
        @(posedge CLK) disable iff (any_reset)
            (wr_top && REG_WDATA[BIT_OVERVOLT] && !(ovp_s && !ovp_prev))
            |=> !top_flag[BIT_OVERVOLT];
    endproperty
    a_top_clear: assert property (p_top_clear) else $error("flag not cleared"); // (R14)

    property p_gated_pok;
        @(posedge CLK) disable iff (any_reset)
            (FAULT_GATING_SELECT && $past(FAULT_GATING_SELECT) && (fault_flag != FAULT_RESET))
            |-> !pok;
    endproperty
    a_gated_pok: assert property (p_gated_pok) else $error("power-ok high on fault"); // (R15)

    property p_outputs_low;
        @(posedge CLK) disable iff (any_reset)
            (top_flag[BIT_THERM_SD] || top_flag[BIT_OVERVOLT])
            |-> (!GENERAL_OUTPUT_A && !GENERAL_OUTPUT_B);
    endproperty
    a_outputs_low: assert property (p_outputs_low) else $error("outputs high in fault"); // (R9)
endmodule : rfir_top

// >>> rfir_pkg.sv
// constants for the regulator fault and top interrupt register block
// ---------------------------------------------------------------
// Summary of operation
// (R1) fault flag sets when a monitored regulator output drops power-ok
// (R2) fault flag clears on written one only while that output is valid
// (R3) soft reset command returns registers to defaults and restarts interface
// (R4) soft reset command bit clears itself and never reads back set
// (R5) power-ok drop flag latches on power-ok active to inactive change
// (R6) linreg summary bit is read-only, high while any linreg flag pending
// (R7) stepdown summary bit is read-only, high while any stepdown flag pending
// (R8) clock-sync flag latches when external clock appears or disappears
// (R9) thermal shutdown latches flag, disables regulators, drives outputs low
// (R10) regulators cannot be enabled while thermal shutdown flag is set
// (R11) thermal warning flag latches; live warning readable separately (this block reads back only the latched flag)
// (R12) overvoltage latches flag, disables regulators, outputs low; live readable (this block reads back only the latched flag)
// (R13) load-current ready flag latches on a new measurement result
// (R14) latched top flags clear on written one and reset to zero
// (R15) with fault gating, power-ok follows fault flags, else live status
// (R16) a regulator counts toward power-ok only when its source bit is set
// (R17) interrupt output high while any unmasked latched top flag is set
// (R18) host writes zero to reserved bits and ignores their read value
// ---------------------------------------------------------------
package rfir_pkg;
    localparam logic [7:0] ADDR_FAULT_SRC  = 8'h17;
    localparam logic [7:0] ADDR_SOFT_RESET = 8'h18;
    localparam logic [7:0] ADDR_TOP_FLAGS  = 8'h19;
    localparam logic [7:0] RESET_VALUE     = 8'h00;
    localparam logic [3:0] FAULT_RESET     = 4'h0;
    localparam int         NUM_REG         = 4;
    localparam int         BIT_SOFT_RESET  = 0;
    localparam int         BIT_POK_DROP    = 7;
    localparam int         BIT_LINREG_SUM  = 6;
    localparam int         BIT_STEP_SUM    = 5;
    localparam int         BIT_CLK_SYNC    = 4;
    localparam int         BIT_THERM_SD    = 3;
    localparam int         BIT_THERM_WARN  = 2;
    localparam int         BIT_OVERVOLT    = 1;
    localparam int         BIT_LOAD_MEAS   = 0;
    // latched top flags, without the two read-only summaries
    localparam logic [7:0] TOP_LATCH_MASK  = 8'h9F;
    localparam logic [7:0] TOP_SUM_MASK    = 8'h60;
endpackage : rfir_pkg

// >>> rfir_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module rfir_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage;
    logic [WIDTH-1:0] next_stage;
    logic [WIDTH-1:0] next_dout;

    // a zero-width synchroniser has nothing to carry
    if (WIDTH < 1) begin : g_bad_width
        $error("rfir_sync: width must be at least one");
    end

    always_comb begin
        next_stage = din;
        next_dout  = stage;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stage <= '0;
            dout  <= '0;
        end else begin
            stage <= next_stage;
            dout  <= next_dout;
        end
    end
endmodule : rfir_sync

// >>> rfir_host.sv
// host model that issues register writes and reads
`timescale 1ns/1ps
module rfir_host
    import rfir_pkg::*;
(
    input  wire logic       clk,
    output logic            wr,
    output logic            rd,
    output logic [7:0]      addr,
    output logic [7:0]      wdata,
    input  wire logic [7:0] rdata
);
    initial begin
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
    end

    // one access: strobe held over one rising edge, answer taken after it
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        @(negedge clk);
        addr <= a;
        wdata <= d & ((a == ADDR_FAULT_SRC) ? 8'h0F : (a == ADDR_SOFT_RESET) ? 8'h01 : 8'hFF);
        wr <= w;
        rd <= !w;
        @(posedge clk);
        @(negedge clk);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        // released bus must not look like a held request
        addr <= ~a;
        wdata <= ~d;
    endtask : xfer
endmodule : rfir_host

// >>> tb_rfir_top.sv
// self-checking bench for the fault source and top flag block
`timescale 1ns/1ps
module tb_rfir_top
    import rfir_pkg::*;
;
    typedef struct packed {
        logic [4:0] ev;
        logic [7:0] mask;
        logic       irq;
    } rfir_row_t;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [3:0] valid = 4'hF;
    logic [3:0] src = 4'h0;
    logic [4:0] ev = 5'h00;
    logic [7:0] step = 8'h00;
    logic [7:0] lin = 8'h00;
    logic [7:0] mask = 8'h00;
    logic       gate = 1'b0;
    logic [3:0] req = 4'hF;
    logic [1:0] greq = 2'b11;
    logic       wr, rd, goa, gob, pok, srp, irq;
    logic [7:0] addr, wdata, rdata, got;
    logic [3:0] en;
    int         failures = 0;
    int         checks = 0;
    rfir_row_t  rows [5];

    always #5 clk = ~clk;

    rfir_host u_host (.clk(clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata), .rdata(rdata));

    rfir_top u_dut (.CLK(clk), .RST(rst), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .OUTPUT_VALID(valid), .POWER_OK_SOURCE(src),
        .FAULT_GATING_SELECT(gate), .EXT_CLK_PRESENT(ev[4]), .THERMAL_SHUTDOWN_LIVE(ev[3]),
        .THERMAL_WARNING_LIVE(ev[2]), .INPUT_OVERVOLTAGE_LIVE(ev[1]),
        .LOAD_CURRENT_DONE(ev[0]), .STEPDOWN_IRQ_REGISTER(step), .LINREG_IRQ_REGISTER(lin),
        .TOP_IRQ_MASK(mask), .REG_ENABLE_REQ(req), .REG_ENABLE(en),
        .GENERAL_OUTPUT_A(goa), .GENERAL_OUTPUT_B(gob), .GENERAL_REQ_A(greq[0]),
        .GENERAL_REQ_B(greq[1]), .POWER_OK_OUTPUT(pok), .SOFT_RESET_PULSE(srp), .IRQ(irq));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk8

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        u_host.xfer(1'b1, a, d, got);
    endtask : wreg

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        u_host.xfer(1'b0, a, 8'h00, got);
        chk8(got, e);
    endtask : rdc

    task automatic summarize;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        rows[0] = '{5'h01, 8'h00, 1'b1};
        rows[1] = '{5'h02, 8'h01, 1'b1};
        rows[2] = '{5'h04, 8'h04, 1'b0};
        rows[3] = '{5'h08, 8'h00, 1'b1};
        rows[4] = '{5'h10, 8'h00, 1'b1};
        repeat (20) @(negedge clk);
        rst = 1'b0;
        rdc(ADDR_FAULT_SRC, 8'h00);
        rdc(ADDR_TOP_FLAGS, 8'h00);
        rdc(8'h20, 8'h00);
        chk8({7'h00, irq}, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            mask = rows[i].mask;
            ev = rows[i].ev;
            cyc(5);
            rdc(ADDR_TOP_FLAGS, {3'b000, rows[i].ev});
            chk8({7'h00, irq}, {7'h00, rows[i].irq});
            chk8({4'h0, en}, (rows[i].ev & 5'h0A) != 0 ? 8'h00 : 8'h0F);
            chk8({6'h00, gob, goa}, (rows[i].ev & 5'h0A) != 0 ? 8'h00 : 8'h03);
            wreg(ADDR_TOP_FLAGS, 8'h1F);
            rdc(ADDR_TOP_FLAGS, 8'h00);
            ev = 5'h00;
            cyc(5);
            rdc(ADDR_TOP_FLAGS, {3'b000, rows[i].ev & 5'h10});
            wreg(ADDR_TOP_FLAGS, 8'h1F);
            rdc(ADDR_TOP_FLAGS, 8'h00);
            $display("test row %0d done", i);
        end
        mask = 8'h00;
        // summaries are read-only and follow the per-regulator registers
        lin = 8'h40;
        wreg(ADDR_TOP_FLAGS, 8'h60);
        rdc(ADDR_TOP_FLAGS, 8'h40);
        chk8({7'h00, irq}, 8'h01);
        lin = 8'h00;
        step = 8'h04;
        rdc(ADDR_TOP_FLAGS, 8'h20);
        step = 8'h00;
        rdc(ADDR_TOP_FLAGS, 8'h00);
        $display("test summaries done");
        // requests pass straight through while nothing is shut
        req = 4'h5;
        greq = 2'b10;
        cyc(1);
        chk8({4'h0, en}, 8'h05);
        chk8({6'h00, gob, goa}, 8'h02);
        req = 4'hF;
        greq = 2'b11;
        $display("test pass-through done");
        src = 4'h4;
        valid = 4'hE;
        cyc(6);
        rdc(ADDR_FAULT_SRC, 8'h00);
        chk8({7'h00, pok}, 8'h01);
        valid = 4'hA;
        cyc(6);
        rdc(ADDR_FAULT_SRC, 8'h04);
        // read data stands one cycle only, then returns to zero
        cyc(1);
        chk8(rdata, 8'h00);
        rdc(ADDR_TOP_FLAGS, 8'h80);
        chk8({7'h00, pok}, 8'h00);
        wreg(ADDR_FAULT_SRC, 8'h04);
        rdc(ADDR_FAULT_SRC, 8'h04);
        valid = 4'hF;
        cyc(6);
        chk8({7'h00, pok}, 8'h01);
        gate = 1'b1;
        cyc(3);
        chk8({7'h00, pok}, 8'h00);
        wreg(ADDR_FAULT_SRC, 8'h00);
        rdc(ADDR_FAULT_SRC, 8'h04);
        wreg(ADDR_FAULT_SRC, 8'h04);
        rdc(ADDR_FAULT_SRC, 8'h00);
        cyc(3);
        chk8({7'h00, pok}, 8'h01);
        $display("test fault flags done");
        // soft reset with a fault and two top flags pending
        valid = 4'hB;
        ev = 5'h01;
        cyc(6);
        valid = 4'hF;
        ev = 5'h00;
        cyc(6);
        wreg(ADDR_SOFT_RESET, 8'h01);
        chk8({7'h00, srp}, 8'h01);
        cyc(1);
        chk8({7'h00, srp}, 8'h00);
        rdc(ADDR_FAULT_SRC, 8'h00);
        rdc(ADDR_TOP_FLAGS, 8'h00);
        rdc(ADDR_SOFT_RESET, 8'h00);
        $display("test soft reset done");
        // a second reset in mid-run with a fault and two flags pending;
        // a selected source must not read as faulty while the synchroniser refills
        valid = 4'hB;
        ev = 5'h02;
        cyc(6);
        rst = 1'b1;
        valid = 4'hF;
        ev = 5'h00;
        cyc(2);
        rst = 1'b0;
        rdc(ADDR_FAULT_SRC, 8'h00);
        rdc(ADDR_TOP_FLAGS, 8'h00);
        chk8({4'h0, en}, 8'h0F);
        chk8({7'h00, pok}, 8'h01);
        $display("test mid-run reset done");
        summarize();
    end

    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        summarize();
    end
endmodule : tb_rfir_top
